// ==== rtl/pfs_defs.vh ====
// register offsets, field positions and reset values for the pin function select block
`ifndef PFS_DEFS_VH
`define PFS_DEFS_VH

// register word addresses (byte address, one aligned word each)
`define PFS_ADDR_QDEC_SEL        8'h00
`define PFS_ADDR_EXT_BUS_EN      8'h04
`define PFS_ADDR_WIDTH           8

// quadrature select fields
`define PFS_QIDX_HI              5
`define PFS_QIDX_LO              4
`define PFS_QB_HI                3
`define PFS_QB_LO                2
`define PFS_QA_HI                1
`define PFS_QA_LO                0
`define PFS_QSEL_RESET           6'h00

// external bus enable fields
`define PFS_EN_ADDR_HI           31
`define PFS_EN_ADDR_LO           16
`define PFS_EN_ADDR8             15
`define PFS_EN_ADDR0             14
`define PFS_EN_CS_HI             13
`define PFS_EN_CS_LO             7
`define PFS_EN_CTRL_HI           6
`define PFS_EN_BUS_CLK           2
`define PFS_EN_FLASH_STB         6
`define PFS_EN_READ_STB          5
`define PFS_EN_BYTE_MASK         4
`define PFS_EN_WRITE_STB         3
`define PFS_EN_WIDTH_HI          1
`define PFS_EN_WIDTH_LO          0
`define PFS_EXT_EN_RESET         32'h0000_0000

// codes of a two-bit pin variant selector
`define PFS_VAR1_CODE            2'h2
`define PFS_VAR2_CODE            2'h3

`endif

// ==== rtl/pfs_pin_function_select.v ====
// pin function select: quadrature input routing and external bus output enables
`timescale 1ns/1ns
`include "pfs_defs.vh"

// How it works
// - index selector bits 5:4, codes pick variant
// - phase B selector bits 3:2, same coding
// - phase A selector bits 1:0, same coding
// - quadrature selects survive deep standby reset
// - bits 31:16 addr 24..9, 15 addr8, 14 addr0
// - bits 13:7 chip selects, 6:0 control strobes
// - address enable 1 drives pin, 0 releases
// - enable register read/write, resets to zero
// - reads return last written value, no side effect
// - bit 2 absent on smallest variant
// - chip select enable drives active-low select
module pfs_pin_function_select #(
    parameter HAS_BUS_CLK = 1                       // 0 on the smallest product variant
) (
    input  wire        i_clk,
    input  wire        i_rst,
    input  wire        i_deep_standby_rst,          // synchronous, clears only the external bus enables; quadrature selects and other registers keep their values
    input  wire [7:0]  i_addr,
    input  wire [31:0] i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [31:0] o_rdata,
    // quadrature candidate pins (asynchronous)
    input  wire        i_qdec0_index_pin_v0,
    input  wire        i_qdec0_index_pin_v1,
    input  wire        i_qdec0_index_pin_v2,
    input  wire        i_qdec0_phase_b_pin_v0,
    input  wire        i_qdec0_phase_b_pin_v1,
    input  wire        i_qdec0_phase_b_pin_v2,
    input  wire        i_qdec0_phase_a_pin_v0,
    input  wire        i_qdec0_phase_a_pin_v1,
    input  wire        i_qdec0_phase_a_pin_v2,
    output reg         o_qdec0_index,
    output reg         o_qdec0_phase_b,
    output reg         o_qdec0_phase_a,
    // external bus controller signals, one per enable bit, same bit order
    input  wire [31:0] i_ext_bus_func,
    // alternate owner (gpio or other function) of the same pins
    input  wire [31:0] i_alt_out,
    input  wire [31:0] i_alt_oe,
    output reg  [31:0] o_pin_out,
    output reg  [31:0] o_pin_oe,
    output wire [31:0] o_ext_bus_enables
);

    localparam CAND_PINS = 9;                       // three inputs, three pin variants each
    localparam PIN_COUNT = 32;                      // one enable bit per external bus pin

    reg  [5:0]  qdec_sel;
    reg  [31:0] external_bus_pin_enables;
    wire        wr_qdec_sel;
    wire        wr_bus_en;
    wire [1:0]  qdec0_index_input_sel;
    wire [1:0]  qdec0_phase_b_input_sel;
    wire [1:0]  qdec0_phase_a_input_sel;
    wire [8:0]  cand_pins;
    wire [8:0]  pins_synced;
    wire [2:0]  idx_sync2;
    wire [2:0]  pb_sync2;
    wire [2:0]  pa_sync2;
    reg         next_index;
    reg         next_phase_b;
    reg         next_phase_a;
    wire [31:0] mapped_enables;
    wire [31:0] next_pin_out;
    wire [31:0] next_pin_oe;
    wire [31:0] impl_mask;
    // one named enable per external bus signal, bit 31 down to bit 0
    wire        ext_addr24_out_en;
    wire        ext_addr23_out_en;
    wire        ext_addr22_out_en;
    wire        ext_addr21_out_en;
    wire        ext_addr20_out_en;
    wire        ext_addr19_out_en;
    wire        ext_addr18_out_en;
    wire        ext_addr17_out_en;
    wire        ext_addr16_out_en;
    wire        ext_addr15_out_en;
    wire        ext_addr14_out_en;
    wire        ext_addr13_out_en;
    wire        ext_addr12_out_en;
    wire        ext_addr11_out_en;
    wire        ext_addr10_out_en;
    wire        ext_addr9_out_en;
    wire        ext_addr8_out_en;
    wire        ext_addr0_out_en;
    wire        ext_chipsel7_out_en;
    wire        ext_chipsel6_out_en;
    wire        ext_chipsel5_out_en;
    wire        ext_chipsel4_out_en;
    wire        ext_chipsel3_out_en;
    wire        ext_chipsel2_out_en;
    wire        ext_chipsel1_out_en;
    wire        ext_flash_strobe_out_en;
    wire        ext_read_strobe_out_en;
    wire        ext_byte_mask_out_en;
    wire        ext_write_strobe_out_en;
    wire        ext_bus_clock_out_en;
    wire        ext_data_width_ctrl_hi;
    wire        ext_data_width_ctrl_lo;

    // bus clock enable does not exist on the smallest variant
    assign impl_mask = (HAS_BUS_CLK != 0) ? 32'hffff_ffff
                     : ~(32'h0000_0001 << `PFS_EN_BUS_CLK);
    assign o_ext_bus_enables = external_bus_pin_enables;

    // register write decodes; an unmapped address matches neither and is dropped
    assign wr_qdec_sel = i_wr && (i_addr == `PFS_ADDR_QDEC_SEL);
    assign wr_bus_en   = i_wr && (i_addr == `PFS_ADDR_EXT_BUS_EN);

    // the three quadrature selector fields of the select register
    assign qdec0_index_input_sel   = qdec_sel[`PFS_QIDX_HI:`PFS_QIDX_LO];
    assign qdec0_phase_b_input_sel = qdec_sel[`PFS_QB_HI:`PFS_QB_LO];
    assign qdec0_phase_a_input_sel = qdec_sel[`PFS_QA_HI:`PFS_QA_LO];

    // named view of the enable bits: address 24..9 on 31..16, then 8 and 0
    assign ext_addr24_out_en       = external_bus_pin_enables[`PFS_EN_ADDR_LO + 15];
    assign ext_addr23_out_en       = external_bus_pin_enables[`PFS_EN_ADDR_LO + 14];
    assign ext_addr22_out_en       = external_bus_pin_enables[`PFS_EN_ADDR_LO + 13];
    assign ext_addr21_out_en       = external_bus_pin_enables[`PFS_EN_ADDR_LO + 12];
    assign ext_addr20_out_en       = external_bus_pin_enables[`PFS_EN_ADDR_LO + 11];
    assign ext_addr19_out_en       = external_bus_pin_enables[`PFS_EN_ADDR_LO + 10];
    assign ext_addr18_out_en       = external_bus_pin_enables[`PFS_EN_ADDR_LO + 9];
    assign ext_addr17_out_en       = external_bus_pin_enables[`PFS_EN_ADDR_LO + 8];
    assign ext_addr16_out_en       = external_bus_pin_enables[`PFS_EN_ADDR_LO + 7];
    assign ext_addr15_out_en       = external_bus_pin_enables[`PFS_EN_ADDR_LO + 6];
    assign ext_addr14_out_en       = external_bus_pin_enables[`PFS_EN_ADDR_LO + 5];
    assign ext_addr13_out_en       = external_bus_pin_enables[`PFS_EN_ADDR_LO + 4];
    assign ext_addr12_out_en       = external_bus_pin_enables[`PFS_EN_ADDR_LO + 3];
    assign ext_addr11_out_en       = external_bus_pin_enables[`PFS_EN_ADDR_LO + 2];
    assign ext_addr10_out_en       = external_bus_pin_enables[`PFS_EN_ADDR_LO + 1];
    assign ext_addr9_out_en        = external_bus_pin_enables[`PFS_EN_ADDR_LO];
    assign ext_addr8_out_en        = external_bus_pin_enables[`PFS_EN_ADDR8];
    assign ext_addr0_out_en        = external_bus_pin_enables[`PFS_EN_ADDR0];
    assign ext_chipsel7_out_en     = external_bus_pin_enables[`PFS_EN_CS_LO + 6];
    assign ext_chipsel6_out_en     = external_bus_pin_enables[`PFS_EN_CS_LO + 5];
    assign ext_chipsel5_out_en     = external_bus_pin_enables[`PFS_EN_CS_LO + 4];
    assign ext_chipsel4_out_en     = external_bus_pin_enables[`PFS_EN_CS_LO + 3];
    assign ext_chipsel3_out_en     = external_bus_pin_enables[`PFS_EN_CS_LO + 2];
    assign ext_chipsel2_out_en     = external_bus_pin_enables[`PFS_EN_CS_LO + 1];
    assign ext_chipsel1_out_en     = external_bus_pin_enables[`PFS_EN_CS_LO];
    assign ext_flash_strobe_out_en = external_bus_pin_enables[`PFS_EN_FLASH_STB];
    assign ext_read_strobe_out_en  = external_bus_pin_enables[`PFS_EN_READ_STB];
    assign ext_byte_mask_out_en    = external_bus_pin_enables[`PFS_EN_BYTE_MASK];
    assign ext_write_strobe_out_en = external_bus_pin_enables[`PFS_EN_WRITE_STB];
    assign ext_bus_clock_out_en    = external_bus_pin_enables[`PFS_EN_BUS_CLK];
    assign ext_data_width_ctrl_hi  = external_bus_pin_enables[`PFS_EN_WIDTH_HI];
    assign ext_data_width_ctrl_lo  = external_bus_pin_enables[`PFS_EN_WIDTH_LO];

    // enables back in pin order, so the bit-to-signal map is spelled out in one place
    assign mapped_enables = {
        ext_addr24_out_en,
        ext_addr23_out_en,
        ext_addr22_out_en,
        ext_addr21_out_en,
        ext_addr20_out_en,
        ext_addr19_out_en,
        ext_addr18_out_en,
        ext_addr17_out_en,
        ext_addr16_out_en,
        ext_addr15_out_en,
        ext_addr14_out_en,
        ext_addr13_out_en,
        ext_addr12_out_en,
        ext_addr11_out_en,
        ext_addr10_out_en,
        ext_addr9_out_en,
        ext_addr8_out_en,
        ext_addr0_out_en,
        ext_chipsel7_out_en,
        ext_chipsel6_out_en,
        ext_chipsel5_out_en,
        ext_chipsel4_out_en,
        ext_chipsel3_out_en,
        ext_chipsel2_out_en,
        ext_chipsel1_out_en,
        ext_flash_strobe_out_en,
        ext_read_strobe_out_en,
        ext_byte_mask_out_en,
        ext_write_strobe_out_en,
        ext_bus_clock_out_en,
        ext_data_width_ctrl_hi,
        ext_data_width_ctrl_lo
    };

    // quadrature selects: the deep standby reset is ignored here on purpose
    always @(posedge i_clk) begin
        if (i_rst) begin
            qdec_sel <= `PFS_QSEL_RESET;
        end else if (wr_qdec_sel) begin
            qdec_sel <= i_wdata[5:0];
        end
    end

    // external bus enables: every bit read/write except bit 2 when HAS_BUS_CLK is 0, all cleared by any reset
    always @(posedge i_clk) begin
        if (i_rst || i_deep_standby_rst) begin
            external_bus_pin_enables <= `PFS_EXT_EN_RESET;
        end else if (wr_bus_en) begin
            external_bus_pin_enables <= i_wdata & impl_mask;
        end
    end

    // read port: data one cycle after the strobe, unmapped reads zero, no side effect
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd) begin
            case (i_addr)
                `PFS_ADDR_QDEC_SEL:   o_rdata <= {{26{1'h0}}, qdec_sel};
                `PFS_ADDR_EXT_BUS_EN: o_rdata <= external_bus_pin_enables;
                default:              o_rdata <= 32'h0000_0000;
            endcase
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end

    // candidate pins in one vector: index v0..v2, then phase b, then phase a
    assign cand_pins = {
        i_qdec0_phase_a_pin_v2,
        i_qdec0_phase_a_pin_v1,
        i_qdec0_phase_a_pin_v0,
        i_qdec0_phase_b_pin_v2,
        i_qdec0_phase_b_pin_v1,
        i_qdec0_phase_b_pin_v0,
        i_qdec0_index_pin_v2,
        i_qdec0_index_pin_v1,
        i_qdec0_index_pin_v0
    };

    // two flip-flops per candidate pin; only the second stage feeds the selectors,
    // so a metastable first stage never reaches the counter inputs
    genvar gs;
    generate
        for (gs = 0; gs < CAND_PINS; gs = gs + 1) begin : g_pin_sync
            reg stage1;
            reg stage2;
            always @(posedge i_clk) begin
                if (i_rst) begin
                    stage1 <= 1'h0;
                    stage2 <= 1'h0;
                end else begin
                    stage1 <= cand_pins[gs];
                    stage2 <= stage1;
                end
            end
            assign pins_synced[gs] = stage2;
        end
    endgenerate

    // synchronised candidates grouped per counter input
    assign idx_sync2 = pins_synced[2:0];
    assign pb_sync2  = pins_synced[5:3];
    assign pa_sync2  = pins_synced[8:6];

    // variant choice: codes 00 and 01 both fall to variant 0
    always @* begin
        case (qdec0_index_input_sel)
            `PFS_VAR1_CODE: next_index = idx_sync2[1];
            `PFS_VAR2_CODE: next_index = idx_sync2[2];
            default:        next_index = idx_sync2[0];
        endcase
        case (qdec0_phase_b_input_sel)
            `PFS_VAR1_CODE: next_phase_b = pb_sync2[1];
            `PFS_VAR2_CODE: next_phase_b = pb_sync2[2];
            default:        next_phase_b = pb_sync2[0];
        endcase
        case (qdec0_phase_a_input_sel)
            `PFS_VAR1_CODE: next_phase_a = pa_sync2[1];
            `PFS_VAR2_CODE: next_phase_a = pa_sync2[2];
            default:        next_phase_a = pa_sync2[0];
        endcase
    end

    // per-pin ownership: an enabled bit hands the pad to the bus function,
    // a cleared bit leaves it to whichever alternate owner holds it now
    genvar gp;
    generate
        for (gp = 0; gp < PIN_COUNT; gp = gp + 1) begin : g_pin_owner
            assign next_pin_out[gp] = mapped_enables[gp] ? i_ext_bus_func[gp]
                                                         : i_alt_out[gp];
            assign next_pin_oe[gp]  = mapped_enables[gp] | i_alt_oe[gp];
        end
    endgenerate

    // registered pad outputs so an ownership change cannot glitch the pad
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_pin_out <= 32'h0000_0000;
            o_pin_oe  <= 32'h0000_0000;
        end else begin
            o_pin_out <= next_pin_out;
            o_pin_oe  <= next_pin_oe;
        end
    end

    // registered counter inputs: three edges from pin to output in all
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_qdec0_index   <= 1'h0;
            o_qdec0_phase_b <= 1'h0;
            o_qdec0_phase_a <= 1'h0;
        end else begin
            o_qdec0_index   <= next_index;
            o_qdec0_phase_b <= next_phase_b;
            o_qdec0_phase_a <= next_phase_a;
        end
    end

endmodule // pfs_pin_function_select

// ==== verif/pfs_chk.sv ====
// assertion checker for the pin function select block
`timescale 1ns/1ns
module pfs_chk #(
    parameter HAS_BUS_CLK = 1
) (
    input wire        i_clk, i_rst, i_deep_standby_rst, i_wr, i_rd,
    input wire [7:0]  i_addr,
    input wire [31:0] i_wdata, o_rdata, i_ext_bus_func, i_alt_out, i_alt_oe,
    input wire [31:0] o_pin_out, o_pin_oe, o_ext_bus_enables
);
    // the bus clock enable reads zero where the part lacks it
    localparam [31:0] MASK = HAS_BUS_CLK ? 32'hffff_ffff : 32'hffff_fffb;
    wire        wr_en = i_wr && i_addr == 8'h04 && !i_deep_standby_rst;
    wire        unmap = i_addr != 8'h00 && i_addr != 8'h04;
    wire [31:0] en    = o_ext_bus_enables;
    wire [31:0] oe_n  = en | i_alt_oe;
    wire [31:0] out_n = (en & i_ext_bus_func) | (~en & i_alt_out);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_wr; wr_en |=> en == ($past(i_wdata) & MASK); endproperty
    a_wr: assert property (p_wr) else $error("enable write lost");
    property p_deep; i_deep_standby_rst |=> en == 32'h0; endproperty
    a_deep: assert property (p_deep) else $error("enables kept");
    property p_rst; $fell(i_rst) |-> en == 32'h0 && o_pin_oe == 32'h0; endproperty
    a_rst: assert property (p_rst) else $error("pins driven after reset");
    property p_oe; !$past(i_rst) |-> o_pin_oe == $past(oe_n); endproperty
    a_oe: assert property (p_oe) else $error("pin enable wrong");
    property p_out; !$past(i_rst) |-> o_pin_out == $past(out_n); endproperty
    a_out: assert property (p_out) else $error("pin level wrong");
    property p_rd4; i_rd && i_addr == 8'h04 |=> o_rdata == $past(en); endproperty
    a_rd4: assert property (p_rd4) else $error("enable read wrong");
    property p_rdq; i_rd && i_addr == 8'h00 |=> o_rdata[31:6] == 26'h0; endproperty
    a_rdq: assert property (p_rdq) else $error("select read wide");
    property p_idle; !i_rd || unmap |=> o_rdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data not idle");
endmodule // pfs_chk
bind pfs_pin_function_select pfs_chk #(.HAS_BUS_CLK(HAS_BUS_CLK)) pfs_chk_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_deep_standby_rst(i_deep_standby_rst), .i_wr(i_wr),
    .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .i_ext_bus_func(i_ext_bus_func), .i_alt_out(i_alt_out), .i_alt_oe(i_alt_oe),
    .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_ext_bus_enables(o_ext_bus_enables));

// ==== verif/pfs_far.sv ====
// far side model: bus controller, alternate pin owner and quadrature pins
`timescale 1ns/1ns
module pfs_far (
    input  wire        i_clk,
    input  wire [31:0] i_seed,
    output reg  [31:0] o_func,
    output reg  [31:0] o_alt_out,
    output reg  [31:0] o_alt_oe,
    output reg  [8:0]  o_qpin
);
    initial {o_func, o_alt_out, o_alt_oe, o_qpin} = 105'h0;
    // every line moves each cycle so a stale value never passes
    always @(posedge i_clk) begin
        o_func    <= i_seed;
        o_alt_out <= {i_seed[15:0], i_seed[31:16]};
        o_alt_oe  <= ~i_seed;
        o_qpin    <= i_seed[8:0] ^ i_seed[24:16];
    end
endmodule // pfs_far

// ==== verif/tb_top.sv ====
// self-checking bench for the pin function select block
`timescale 1ns/1ns
`include "pfs_defs.vh"
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin bad_count++; \
    $display("mismatch %s exp %h got %h", n, e, s); end end
module tb_top;
    logic        i_clk = 0, i_rst = 1, i_deep_standby_rst = 0, i_wr = 0, i_rd = 0;
    logic [7:0]  i_addr = 0;
    logic [31:0] i_wdata = 0, seed = 32'd40402, v, f, ao, aoe;
    wire  [31:0] o_rdata, func, alt_out, alt_oe, o_pin_out, o_pin_oe, bus_en;
    wire  [8:0]  qp;
    wire         qi, qb, qa;
    logic [8:0]  hist[$];
    logic [5:0]  q;
    logic [2:0]  qe;
    int          bad_count = 0, comparisons = 0;
    pfs_far pfs_far_i (.i_clk, .i_seed(seed), .o_func(func), .o_alt_out(alt_out),
        .o_alt_oe(alt_oe), .o_qpin(qp));
    pfs_pin_function_select pfs_pin_function_select_i (.i_clk, .i_rst, .i_deep_standby_rst,
        .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_ext_bus_func(func), .i_alt_out(alt_out),
        .i_qdec0_index_pin_v0(qp[0]), .i_qdec0_index_pin_v1(qp[1]), .i_qdec0_index_pin_v2(qp[2]),
        .i_qdec0_phase_b_pin_v0(qp[3]), .i_qdec0_phase_b_pin_v1(qp[4]),
        .i_qdec0_phase_b_pin_v2(qp[5]), .i_qdec0_phase_a_pin_v0(qp[6]),
        .i_qdec0_phase_a_pin_v1(qp[7]), .i_qdec0_phase_a_pin_v2(qp[8]), .o_qdec0_index(qi),
        .o_qdec0_phase_b(qb), .o_qdec0_phase_a(qa), .i_alt_oe(alt_oe), .o_pin_out, .o_pin_oe,
        .o_ext_bus_enables(bus_en));
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function pick(input [1:0] c, input [2:0] p);
        pick = c < 2 ? p[0] : c == 2 ? p[1] : p[2];
    endfunction
    always #20 i_clk = ~i_clk;
    // fresh far-side values every cycle
    always @(posedge i_clk) seed <= lfsr(seed);
    task wr(input [7:0] a, input [31:0] d);
        @(posedge i_clk) {i_addr, i_wdata, i_wr} <= {a, d, 1'b1};
        @(posedge i_clk) i_wr <= 0;
    endtask
    task rd(input [7:0] a, input [31:0] e);
        @(posedge i_clk) {i_addr, i_rd} <= {a, 1'b1};
        @(posedge i_clk) i_rd <= 0;
        #1 `CHK("rdata", e, o_rdata)
    endtask
    // pins take one registered cycle after the enable settles
    task pchk(input [31:0] e);
        #1 {f, ao, aoe} = {func, alt_out, alt_oe};
        @(posedge i_clk) #1 `CHK("pin_oe", e | aoe, o_pin_oe)
        `CHK("pin_out", (e & f) | (~e & ao), o_pin_out)
        `CHK("bus_en", e, bus_en)
    endtask
    // pin history model: output follows the pin three edges late
    task qchk(input [5:0] s);
        hist = {};
        repeat (12) begin
            @(posedge i_clk) #1 hist.push_front(qp);
            if (hist.size() > 3) begin
                qe = {pick(s[5:4], hist[3][2:0]), pick(s[3:2], hist[3][5:3]),
                      pick(s[1:0], hist[3][8:6])};
                `CHK("qdec", qe, {qi, qb, qa})
            end
        end
    endtask
    task final_report;
        if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        v = seed;
        repeat (12) @(posedge i_clk);
        i_rst <= 0;
        rd(`PFS_ADDR_QDEC_SEL, 0);
        rd(`PFS_ADDR_EXT_BUS_EN, 0);
        for (int n = 0; n < 7; n++) begin
            v = n == 6 ? 32'hffff_ffff : lfsr(v) ^ {v[15:0], v[31:16]};
            wr(`PFS_ADDR_EXT_BUS_EN, v);
            pchk(v);
            rd(`PFS_ADDR_EXT_BUS_EN, v);
        end
        wr(8'h08, 32'h0);
        rd(8'h08, 0);
        rd(`PFS_ADDR_EXT_BUS_EN, v);
        for (int c = 0; c < 4; c++) begin
            q = {c[1:0], c[1:0] + 2'h1, c[1:0] + 2'h2};
            wr(`PFS_ADDR_QDEC_SEL, {26'h3ff_ffff, q});
            rd(`PFS_ADDR_QDEC_SEL, {26'h0, q});
            qchk(q);
        end
        @(posedge i_clk) i_deep_standby_rst <= 1;
        @(posedge i_clk) i_deep_standby_rst <= 0;
        rd(`PFS_ADDR_QDEC_SEL, {26'h0, q});
        rd(`PFS_ADDR_EXT_BUS_EN, 0);
        @(posedge i_clk) i_rst <= 1;
        @(posedge i_clk) i_rst <= 0;
        rd(`PFS_ADDR_QDEC_SEL, 0);
        final_report;
    end
endmodule // tb_top
